// *** hdl/can_stat_pkg.sv ***
package can_stat_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_IRQ_IDENTIFIER = 4'h1;
  localparam logic [3:0] ADDR_BTR = 4'h2;
  localparam logic [3:0] ADDR_NODE = 4'h3;
  localparam int B_INIT = 0;
  localparam int B_IE = 1;
  localparam int B_SIE = 2;
  localparam int B_EIE = 3;
  localparam int B_CCE = 6;
  localparam int B_TST = 7;
  localparam int B_LEC_LO = 8;
  localparam int B_TX_SUCCESS_FLAG = 11;
  localparam int B_RX_SUCCESS_FLAG = 12;
  localparam int B_ERROR_WARNING_STATUS = 14;
  localparam int B_BUSOFF_STATUS = 15;
  localparam int B_NODE_REQ = 0;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [15:0] BTR_RESET = 16'h0000;
  localparam logic [15:0] BTR_MASK = 16'h7fff;
  localparam logic [8:0] WARN_LIMIT = 9'h060;
  localparam logic [3:0] RECESSIVE_RUN = 4'hb;
  localparam logic [7:0] ID_IDLE = 8'h00;
  localparam logic [7:0] ID_STATUS = 8'h01;
  localparam logic [7:0] ID_OBJ_BASE = 8'h02;
  localparam int NUM_OBJ = 15;

  typedef enum logic [2:0] {
    LEC_NONE = 3'b000,
    LEC_STUFF = 3'b001,
    LEC_FORM = 3'b010,
    LEC_ACK = 3'b011,
    LEC_BIT1 = 3'b100,
    LEC_BIT0 = 3'b101,
    LEC_CRC = 3'b110,
    LEC_UNUSED = 3'b111
  } lec_e;

  typedef struct packed {
    logic tx_ok;
    logic rx_ok;
    logic err_valid;
    lec_e err_code;
    logic recessive_bit;
    logic bit_tick;
    logic busoff_enter;
    logic busoff_exit;
    logic [8:0] tx_err_count;
    logic [8:0] rx_err_count;
  } proto_event_s;

  typedef enum logic [1:0] {
    RUN = 2'b00,
    WAIT_IDLE = 2'b01,
    BUSOFF = 2'b10
  } bus_state_e;
endpackage

// *** hdl/can_status_irq.sv ***
`timescale 1ns/1ps
module can_status_irq (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [15:0] writedata,
  input wire logic [1:0] byteenable,
  output logic [15:0] readdata,
  output logic waitrequest,
  input wire can_stat_pkg::proto_event_s proto,
  input wire logic [can_stat_pkg::NUM_OBJ-1:0] object_irq_pending,
  input wire logic irq_serviced,
  output logic [15:0] bit_timing,
  output logic init_active,
  output logic bus_active,
  output logic can_irq_vector
);
  import can_stat_pkg::*;

  logic [7:0] ctrl;
  lec_e last_error_code;
  logic tx_success_flag;
  logic rx_success_flag;
  logic busoff_status;
  logic status_pending;
  logic [7:0] irq_identifier;
  logic irq_raw;
  logic irq_sync;
  logic node_irq_request_flag;
  logic irq_prev;
  logic done;
  bus_state_e state;
  logic [3:0] run_count;

  logic rd_pending;
  // Reads take one wait state so the registered data already stand when waitrequest
  // drops; writes complete in their first cycle
  wire rd_take = read && !rd_pending;
  assign waitrequest = rd_take;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_pending <= 1'b0;
    end else begin
      rd_pending <= rd_take;
    end
  end

  wire wr_ctrl = write && (address == ADDR_CTRL);
  wire wr_ctrl_lo = wr_ctrl && byteenable[0];
  wire wr_ctrl_hi = wr_ctrl && byteenable[1];
  // Clear on the snapshot cycle, so an event after the snapshot stays pending
  wire rd_status = rd_take && (address == ADDR_CTRL) && byteenable[1];
  wire cfg_change_enable = ctrl[B_CCE];
  wire global_irq_enable = ctrl[B_IE];
  wire status_irq_enable = ctrl[B_SIE];
  wire error_irq_enable = ctrl[B_EIE];
  wire error_warning_status = (proto.tx_err_count >= WARN_LIMIT) ||
    (proto.rx_err_count >= WARN_LIMIT);
  wire wr_btr = write && (address == ADDR_BTR) && cfg_change_enable;
  wire wr_node = write && (address == ADDR_NODE) && byteenable[0];
  wire run_done = proto.bit_tick && proto.recessive_bit && (run_count == RECESSIVE_RUN - 4'h1);
  wire recovery_step = (state == BUSOFF) && !ctrl[B_INIT] && run_done;

  // Hardware events that change status; CPU writes are not among them
  wire transfer_event = proto.tx_ok || proto.rx_ok || proto.err_valid || recovery_step;
  logic error_warning_status_prev;
  wire error_change = (error_warning_status_prev != error_warning_status) || proto.busoff_enter ||
    proto.busoff_exit;
  wire status_set = (status_irq_enable && transfer_event) ||
    (error_irq_enable && error_change);
  wire [15:0] status_word = {busoff_status, error_warning_status, 1'b0, rx_success_flag,
    tx_success_flag, last_error_code, ctrl};

  logic [7:0] next_identifier;
  always_comb begin
    next_identifier = ID_IDLE;
    for (int n = 1; n < NUM_OBJ; n++) begin
      if (object_irq_pending[n-1] && next_identifier == ID_IDLE) begin
        next_identifier = ID_OBJ_BASE + 8'(n);
      end
    end
    if (object_irq_pending[NUM_OBJ-1]) begin
      next_identifier = ID_OBJ_BASE;
    end
    if (status_pending) begin
      next_identifier = ID_STATUS;
    end
  end
  assign irq_identifier = next_identifier;
  assign irq_raw = global_irq_enable && (irq_identifier != ID_IDLE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
    end else if (proto.busoff_enter) begin
      ctrl[B_INIT] <= 1'b1;
    end else if (wr_ctrl_lo) begin
      ctrl <= writedata[7:0] & ~(8'h01 << B_TST);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_error_code <= LEC_NONE;
    end else if (proto.err_valid && proto.err_code != LEC_UNUSED) begin
      last_error_code <= proto.err_code;
    end else if (recovery_step) begin
      last_error_code <= LEC_BIT0;
    end else if (proto.tx_ok || proto.rx_ok) begin
      last_error_code <= LEC_NONE;
    end else if (wr_ctrl_hi) begin
      last_error_code <= lec_e'(writedata[B_LEC_LO +: 3]);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_success_flag <= 1'b0;
      rx_success_flag <= 1'b0;
    end else begin
      tx_success_flag <= proto.tx_ok || (tx_success_flag &&
        !(wr_ctrl_hi && !writedata[B_TX_SUCCESS_FLAG]));
      rx_success_flag <= proto.rx_ok || (rx_success_flag &&
        !(wr_ctrl_hi && !writedata[B_RX_SUCCESS_FLAG]));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_pending <= 1'b0;
      error_warning_status_prev <= 1'b0;
    end else begin
      status_pending <= status_set || (status_pending && !rd_status);
      error_warning_status_prev <= error_warning_status;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= RUN;
      run_count <= 4'h0;
      busoff_status <= 1'b0;
    end else begin
      if (proto.bit_tick) begin
        run_count <= (!proto.recessive_bit || run_done) ? 4'h0 : run_count + 4'h1;
      end
      case (state)
        RUN: begin
          if (proto.busoff_enter) begin
            state <= BUSOFF;
            busoff_status <= 1'b1;
          end else if (ctrl[B_INIT]) begin
            state <= WAIT_IDLE;
          end
        end
        WAIT_IDLE: begin
          if (proto.busoff_enter) begin
            state <= BUSOFF;
            busoff_status <= 1'b1;
          end else if (!ctrl[B_INIT] && run_done) begin
            state <= RUN;
          end
        end
        BUSOFF: begin
          if (proto.busoff_exit) begin
            state <= WAIT_IDLE;
            busoff_status <= 1'b0;
          end
        end
        default: state <= RUN;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_timing <= BTR_RESET;
    end else if (wr_btr) begin
      bit_timing <= writedata & BTR_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_sync <= 1'b0;
      irq_prev <= 1'b0;
      node_irq_request_flag <= 1'b0;
    end else begin
      irq_sync <= irq_raw;
      irq_prev <= irq_sync;
      node_irq_request_flag <= (irq_sync && !irq_prev) || (node_irq_request_flag &&
        !irq_serviced && !(wr_node && !writedata[B_NODE_REQ]));
    end
  end
  assign can_irq_vector = node_irq_request_flag;
  assign init_active = ctrl[B_INIT];
  assign bus_active = (state == RUN) && !ctrl[B_INIT];

  wire [15:0] rd_mux = (address == ADDR_CTRL) ? status_word :
    (address == ADDR_IRQ_IDENTIFIER) ? {8'h00, irq_identifier} :
    (address == ADDR_BTR) ? bit_timing :
    (address == ADDR_NODE) ? {15'h0000, node_irq_request_flag} : 16'h0000;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata <= 16'h0000;
    end else if (rd_take) begin
      readdata <= rd_mux;
    end
  end

  AST_BTR_LOCK: assert property (@(posedge clk) disable iff (rst)
    (write && address == ADDR_BTR && !cfg_change_enable) |=> $stable(bit_timing))
    else $error("bit timing changed while locked");
  AST_TX_HOLD: assert property (@(posedge clk) disable iff (rst)
    proto.tx_ok |=> tx_success_flag)
    else $error("transmit flag not set");
  AST_RX_HOLD: assert property (@(posedge clk) disable iff (rst)
    (rx_success_flag && !wr_ctrl_hi) |=> rx_success_flag)
    else $error("receive flag dropped by hardware");
  AST_LEC_OK: assert property (@(posedge clk) disable iff (rst)
    ((proto.tx_ok || proto.rx_ok) && !proto.err_valid && !recovery_step) |=>
    last_error_code == LEC_NONE)
    else $error("error code not cleared");
  AST_LEC_NO7: assert property (@(posedge clk) disable iff (rst)
    (last_error_code != LEC_UNUSED && !wr_ctrl_hi) |=> last_error_code != LEC_UNUSED)
    else $error("hardware produced code 7");
  AST_IDLE_ID: assert property (@(posedge clk) disable iff (rst)
    (!status_pending && object_irq_pending == '0) |-> irq_identifier == ID_IDLE)
    else $error("identifier nonzero while idle");
  AST_PRIO: assert property (@(posedge clk) disable iff (rst)
    status_pending |-> irq_identifier == ID_STATUS)
    else $error("status change not highest priority");
  AST_RD_CLR: assert property (@(posedge clk) disable iff (rst)
    (rd_status && !status_set) |=> !status_pending)
    else $error("status read did not clear pending");
  AST_LINE: assert property (@(posedge clk) disable iff (rst)
    irq_raw |=> ##1 (irq_sync || !$past(irq_raw)))
    else $error("line not forwarded");
  // Bus handshake: one wait state on reads, none on writes
  AST_RD_WAIT: assert property (@(posedge clk) disable iff (rst)
    (read && !rd_pending) |->
    waitrequest)
    else $error("read answered without wait state");
  AST_RD_DONE: assert property (@(posedge clk) disable iff (rst)
    (read && rd_pending) |->
    !waitrequest)
    else $error("read held in wait too long");
  AST_WR_NOWAIT: assert property (@(posedge clk) disable iff (rst)
    write |->
    !waitrequest)
    else $error("write stalled");
  AST_TST_ZERO: assert property (@(posedge clk) disable iff (rst)
    wr_ctrl_lo |=>
    !ctrl[B_TST])
    else $error("test mode bit stored");
  AST_TX_KEEP: assert property (@(posedge clk) disable iff (rst)
    (tx_success_flag && !wr_ctrl_hi) |=>
    tx_success_flag)
    else $error("transmit flag dropped by hardware");
  AST_STUFF: assert property (@(posedge clk) disable iff (rst)
    (proto.err_valid && proto.err_code == LEC_STUFF) |=>
    last_error_code == LEC_STUFF)
    else $error("stuff error not recorded");
  AST_RECOV: assert property (@(posedge clk) disable iff (rst)
    (recovery_step && !proto.err_valid) |=>
    last_error_code == LEC_BIT0)
    else $error("recovery step not recorded");
  AST_ERROR_WARNING_STATUS: assert property (@(posedge clk) disable iff (rst)
    (proto.tx_err_count >= WARN_LIMIT || proto.rx_err_count >= WARN_LIMIT) |->
    status_word[B_ERROR_WARNING_STATUS])
    else $error("warning status missing");
  AST_BUSOFF_STATUS: assert property (@(posedge clk) disable iff (rst)
    proto.busoff_enter |=>
    busoff_status)
    else $error("busoff status not set");
  AST_BUSOFF_STATUS_INIT: assert property (@(posedge clk) disable iff (rst)
    proto.busoff_enter |=>
    ctrl[B_INIT])
    else $error("busoff did not set init");
  // Leaving the wait state early would join the bus mid-frame
  AST_RUN_WAIT: assert property (@(posedge clk) disable iff (rst)
    (state == WAIT_IDLE && !run_done) |=>
    state != RUN)
    else $error("joined bus before idle run");
  AST_NODE_SET: assert property (@(posedge clk) disable iff (rst)
    (irq_sync && !irq_prev) |=>
    node_irq_request_flag)
    else $error("node request not raised");
  AST_NODE_CLR: assert property (@(posedge clk) disable iff (rst)
    (node_irq_request_flag && irq_serviced && !(irq_sync && !irq_prev)) |=>
    !node_irq_request_flag)
    else $error("node request not cleared on service");
  AST_LINE_OFF: assert property (@(posedge clk) disable iff (rst)
    !global_irq_enable |->
    !irq_raw)
    else $error("line active while disabled");
  AST_OBJ15: assert property (@(posedge clk) disable iff (rst)
    (object_irq_pending[NUM_OBJ-1] && !status_pending) |->
    irq_identifier == ID_OBJ_BASE)
    else $error("object 15 not shown");
  // A plain status write must leave the pending status interrupt alone
  AST_WR_NOIRQ: assert property (@(posedge clk) disable iff (rst)
    (wr_ctrl && !status_set && !rd_status) |=>
    status_pending == $past(status_pending))
    else $error("status write changed interrupt");
  COV_STATUS: cover property (@(posedge clk) rd_status && status_pending);
  COV_OBJ15: cover property (@(posedge clk) irq_identifier == ID_OBJ_BASE);
  COV_RECOVERY: cover property (@(posedge clk) recovery_step);
  COV_SERVICE: cover property (@(posedge clk) node_irq_request_flag && irq_serviced);
endmodule

// *** dv/can_bus_peer.sv ***
`timescale 1ns/1ps
module can_bus_peer (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [2:0] kind,
  input wire can_stat_pkg::lec_e code,
  input wire logic [8:0] tec,
  input wire logic [8:0] rec,
  output can_stat_pkg::proto_event_s proto
);
  import can_stat_pkg::*;
  // Pulses last one cycle; the code is garbage unless flagged valid
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      proto <= '0;
    end else begin
      proto <= '0;
      proto.tx_err_count <= tec;
      proto.rx_err_count <= rec;
      proto.err_code <= (go && kind == 3'h2) ? code : lec_e'(~code);
      if (go) begin
        case (kind)
          3'h0: proto.tx_ok <= 1'b1;
          3'h1: proto.rx_ok <= 1'b1;
          3'h2: proto.err_valid <= 1'b1;
          3'h3: proto.busoff_enter <= 1'b1;
          3'h4: proto.busoff_exit <= 1'b1;
          default: begin
            proto.bit_tick <= 1'b1;
            proto.recessive_bit <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// *** dv/can_status_irq_test.sv ***
`timescale 1ns/1ps
module can_status_irq_test;
  import can_stat_pkg::*;
  logic clk, rst, read, write, go, irq_serviced, waitrequest;
  logic init_active, bus_active, can_irq_vector;
  logic [3:0] address;
  logic [15:0] writedata, readdata, bit_timing, rd;
  logic [1:0] byteenable;
  logic [2:0] kind;
  lec_e code;
  logic [8:0] tec, rec;
  logic [14:0] obj;
  proto_event_s proto;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  typedef struct {logic [2:0] k; logic [2:0] c; logic [7:0] st;} row_s;
  row_s rows[8] = '{'{2, 1, 8'h01}, '{2, 2, 8'h02}, '{2, 3, 8'h03}, '{2, 4, 8'h04},
    '{2, 5, 8'h05}, '{2, 6, 8'h06}, '{0, 0, 8'h08}, '{1, 0, 8'h18}};

  can_status_irq u_can_status_irq (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .proto(proto), .object_irq_pending(obj),
    .irq_serviced(irq_serviced), .bit_timing(bit_timing), .init_active(init_active),
    .bus_active(bus_active), .can_irq_vector(can_irq_vector));
  can_bus_peer u_can_bus_peer (.clk(clk), .rst(rst), .go(go), .kind(kind), .code(code),
    .tec(tec), .rec(rec), .proto(proto));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for waitrequest low; read data are taken at that same edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d,
                     input logic [1:0] be);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !wr;
    write <= wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic ev(input logic [2:0] k, input logic [2:0] c);
    go <= 1'b1;
    kind <= k;
    code <= lec_e'(c);
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    bus(0, a, 16'h0000, 2'b11);
    chk(rd, exp);
  endtask

  initial begin
    rst = 1'b1;
    {read, write, go, irq_serviced} = '0;
    {address, writedata, byteenable, kind, tec, rec, obj} = '0;
    code = LEC_NONE;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(ADDR_CTRL, 16'h0001);
    rd_chk(ADDR_IRQ_IDENTIFIER, 16'h0000);
    bus(1, ADDR_CTRL, 16'h0000, 2'b01);
    foreach (rows[i]) begin
      ev(rows[i].k, rows[i].c);
      rd_chk(ADDR_CTRL, {rows[i].st, 8'h00});
    end
    bus(1, ADDR_CTRL, 16'h0700, 2'b10);
    rd_chk(ADDR_CTRL, 16'h0700);
    ev(2, 3);
    rd_chk(ADDR_CTRL, 16'h0300);
    tec <= 9'd95;
    repeat (2) @(posedge clk);
    rd_chk(ADDR_CTRL, 16'h0300);
    tec <= 9'd96;
    repeat (2) @(posedge clk);
    rd_chk(ADDR_CTRL, 16'h4300);
    {tec, rec} <= {9'd0, 9'd96};
    repeat (2) @(posedge clk);
    rd_chk(ADDR_CTRL, 16'h4300);
    rec <= 9'd0;
    repeat (2) @(posedge clk);
    ev(3, 0);
    rd_chk(ADDR_CTRL, 16'h8301);
    bus(1, ADDR_CTRL, 16'h0000, 2'b01);
    chk({15'h0, bus_active}, 16'h0000);
    repeat (10) ev(5, 0);
    rd_chk(ADDR_CTRL, 16'h8300);
    ev(5, 0);
    rd_chk(ADDR_CTRL, 16'h8500);
    ev(4, 0);
    rd_chk(ADDR_CTRL, 16'h0500);
    bus(1, ADDR_BTR, 16'hffff, 2'b11);
    chk(bit_timing, 16'h0000);
    bus(1, ADDR_CTRL, 16'h0046, 2'b01);
    bus(1, ADDR_BTR, 16'hffff, 2'b11);
    chk(bit_timing, BTR_MASK);
    bus(1, ADDR_CTRL, 16'h0700, 2'b10);
    rd_chk(ADDR_IRQ_IDENTIFIER, 16'h0000);
    ev(0, 0);
    rd_chk(ADDR_IRQ_IDENTIFIER, 16'h0001);
    for (int n = 0; n < 20 && can_irq_vector !== 1'b1; n++) @(posedge clk);
    chk({15'h0, can_irq_vector}, 16'h0001);
    bus(0, ADDR_CTRL, 16'h0000, 2'b01);
    obj <= 15'h4001;
    rd_chk(ADDR_IRQ_IDENTIFIER, 16'h0001);
    irq_serviced <= 1'b1;
    @(posedge clk);
    irq_serviced <= 1'b0;
    repeat (2) @(posedge clk);
    chk({15'h0, can_irq_vector}, 16'h0000);
    bus(0, ADDR_CTRL, 16'h0000, 2'b10);
    rd_chk(ADDR_IRQ_IDENTIFIER, 16'h0002);
    obj <= 15'h0001;
    rd_chk(ADDR_IRQ_IDENTIFIER, 16'h0003);
    {obj, tec} <= {15'h0, 9'd96};
    repeat (2) @(posedge clk);
    rd_chk(ADDR_IRQ_IDENTIFIER, 16'h0000);
    bus(1, ADDR_CTRL, 16'h004e, 2'b01);
    tec <= 9'd0;
    repeat (2) @(posedge clk);
    rd_chk(ADDR_IRQ_IDENTIFIER, 16'h0001);
    summarize();
  end
endmodule
